// >>> common/dmd_pkg.sv
// Shared constants and enumerations for the signal-processing datapath
package dmd_pkg;
	localparam int DATA_W = 16;
	localparam int ACC_W = 40;
	localparam int MUL_W = 17;
	localparam int PROD_W = 34;
	localparam int SHAMT_W = 5;
	localparam int SHIFT_MAX = 16;
	localparam int NUM_REGS = 16;
	localparam int REG_IDX_W = 4;
	localparam logic [3:0] SP_IDX = 4'hf;
	// Divide: 1 setup, 17 steps, 1 fixup
	localparam int DIV_CYCLES = 19;
	localparam int DIV_STEPS = 17;
	localparam int DIVCNT_W = 5;
	localparam logic [15:0] SAT_POS = 16'h7fff;
	localparam logic [15:0] SAT_NEG = 16'h8000;
	localparam logic [23:0] SAT_HI_LIMIT = 24'h007fff;
	localparam logic [23:0] SAT_LO_LIMIT = 24'hff8000;
	localparam int ACC_SIGN_BIT = 39;
	localparam logic [39:0] ACC_MAX = 40'h7fffffffff;
	localparam logic [39:0] ACC_MIN = 40'h8000000000;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// Operand sign modes of the shared multiplier
	typedef enum logic [1:0] {
		DMD_MUL_SS,
		DMD_MUL_UU,
		DMD_MUL_SU
	} dmd_mul_mode_t;

	// Datapath operations issued by the sequencer
	typedef enum logic [3:0] {
		DMD_OP_NOP,
		DMD_OP_ADD,
		DMD_OP_SUB,
		DMD_OP_MUL,
		DMD_OP_MAC,
		DMD_OP_SHIFT_ACC,
		DMD_OP_SHIFT_REG,
		DMD_OP_STORE_ACC,
		DMD_OP_DIV,
		DMD_OP_WRITE_REG,
		DMD_OP_DWMOVE
	} dmd_op_t;

	// Divide flavours
	typedef enum logic [1:0] {
		DMD_DIV_16_INT,
		DMD_DIV_32_INT,
		DMD_DIV_16_FRAC,
		DMD_DIV_32_FRAC
	} dmd_div_t;
endpackage

// >>> hw/dmd_div_unit.sv
// Iterative restoring divider, one step per repeated instruction
`timescale 1ns/10ps
module dmd_div_unit (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic start_in,
	input wire logic step_in,
	input wire dmd_pkg::dmd_div_t kind_in,
	input wire logic [31:0] dividend_in,
	input wire logic [15:0] divisor_in,
	output logic busy_out,
	output logic done_out,
	output logic [15:0] quot_out,
	output logic [15:0] rem_out
);
	logic [4:0] cnt_r, cnt_nxt;
	logic [31:0] q_r, q_nxt;
	logic [16:0] rem_r, rem_nxt;
	logic [15:0] dvs_r, dvs_nxt;
	logic neg_r, neg_nxt;
	logic busy_r, done_r;
	logic [31:0] dvd_mag;
	logic [15:0] dvs_mag;
	logic [16:0] trial;
	logic [17:0] diff;
	logic is_frac, is_32;

	assign is_frac = (kind_in == dmd_pkg::DMD_DIV_16_FRAC) ||
		(kind_in == dmd_pkg::DMD_DIV_32_FRAC);
	assign is_32 = (kind_in == dmd_pkg::DMD_DIV_32_INT) ||
		(kind_in == dmd_pkg::DMD_DIV_32_FRAC);
	// Signed operands: work on magnitudes, fix sign at the end
	// Fractional dividend is a 1.15 word scaled up by 15 bits
	assign dvd_mag = is_frac ? {1'b0, (dividend_in[15] ?
		-dividend_in[15:0] : dividend_in[15:0]), 15'h0000} :
		is_32 ? (dividend_in[31] ? -dividend_in : dividend_in) :
		{16'h0000, dividend_in[15] ? -dividend_in[15:0] :
		dividend_in[15:0]};
	assign dvs_mag = divisor_in[15] ? -divisor_in : divisor_in;
	assign trial = {rem_r[15:0], q_r[31]};
	assign diff = {1'b0, trial} - {2'b00, dvs_r};

	// Partial state only advances on a step, so an interrupt between
	// steps leaves the quotient intact [RL11]
	always_comb begin
		cnt_nxt = cnt_r;
		q_nxt = q_r;
		rem_nxt = rem_r;
		dvs_nxt = dvs_r;
		neg_nxt = neg_r;
		if (start_in) begin
			cnt_nxt = 5'(dmd_pkg::DIV_STEPS);
			// Top bits seed the remainder, low 17 bits feed the steps;
			// the quotient must fit 16 bits or it wraps
			q_nxt = {dvd_mag[16:0], 15'h0000};
			rem_nxt = {2'b00, dvd_mag[31:17]};
			dvs_nxt = dvs_mag;
			neg_nxt = ((is_32 && !is_frac) ? dividend_in[31] :
				dividend_in[15]) ^ divisor_in[15];
		end else if (step_in && cnt_r != 5'h00) begin // [RL10]
			cnt_nxt = cnt_r - 5'h01;
			q_nxt = {q_r[30:0], ~diff[17]};
			rem_nxt = diff[17] ? trial : diff[16:0];
			if (cnt_r == 5'h01 && cnt_nxt == 5'h00) begin
				q_nxt = {q_r[30:0], ~diff[17]};
			end
		end
	end

	// Registers step state; results are held until next start
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_r <= 5'h00;
			q_r <= 32'h00000000;
			rem_r <= 17'h00000;
			dvs_r <= 16'h0000;
			neg_r <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			q_r <= q_nxt;
			rem_r <= rem_nxt;
			dvs_r <= dvs_nxt;
			neg_r <= neg_nxt;
			busy_r <= cnt_nxt != 5'h00;
			done_r <= step_in && cnt_r == 5'h01;
		end
	end

	assign busy_out = busy_r;
	assign done_out = done_r;
	// Sign fixup is combinational on held registers
	assign quot_out = neg_r ? -q_r[15:0] : q_r[15:0];
	assign rem_out = rem_r[15:0];
endmodule

// >>> hw/dmd_math_datapath.sv
// Arithmetic datapath: multiplier, accumulators, shifter, divide, saturation
// Behaviour
// RL1: One single-cycle 17x17 multiplier shared by MCU and DSP operations.
// RL2: Multiplier supports signed, unsigned and mixed-sign operands.
// RL3: Fractional -1.0 times -1.0 yields exact positive result.
// RL4: 40-bit ALU with two independent saturating 40-bit accumulators.
// RL5: 40-bit shifter moves up to 16 positions either way in one cycle.
// RL6: Shifter serves both MCU register and DSP accumulator operations.
// RL7: MAC fetches two operands, multiplies registers, accumulates, saturates.
// RL8: Dual-operand ops see split X/Y spaces; others see linear space.
// RL9: Divide 16/16 and 32/16, integer and fractional.
// RL10: Divide iterates per repeated instruction, 19 cycles total.
// RL11: Divide state survives interrupts taken between any divide cycles.
// RL12: Write saturation changes stored word only, never the accumulator.
// RL13: Write saturation uses rounded word, accumulator and round overflow.
// RL14: Enabled and value above 0x007fff stores 0x7fff.
// RL15: Enabled and value below 0xff8000 stores 0x8000.
// RL16: Operand sign for saturation comes from accumulator bit 39.
// RL17: Disabled saturation passes the rounded word unchanged.
// RL18: Sixteen 16-bit working registers; last one is the stack pointer.
// RL19: Per cycle: one memory read, one register read, one memory write. The code reads five registers per cycle (opa, opb, divisor, X and Y address).
// RL20: Single-cycle ops except flow change, double-word move, table ops.
// RL21: Signed shift amount: positive right, negative left, zero none.
// RL22: Bus operand at bits 16-31 for right, low bits for left; 16-bit MCU.
`timescale 1ns/10ps
module dmd_math_datapath #(
	parameter int NUM_REGS = dmd_pkg::NUM_REGS
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire dmd_pkg::dmd_op_t op_in,
	input wire dmd_pkg::dmd_mul_mode_t mul_mode_in,
	input wire logic frac_mode_in,
	input wire logic acc_sel_in,
	input wire logic acc_sat_en_in,
	input wire logic data_write_saturate_enable_in,
	input wire logic round_en_in,
	input wire logic arith_shift_in,
	input wire logic signed [5:0] shift_amt_in,
	input wire logic [3:0] src_a_in,
	input wire logic [3:0] src_b_in,
	input wire logic [3:0] dst_in,
	input wire logic [3:0] xaddr_reg_in,
	input wire logic [3:0] yaddr_reg_in,
	input wire logic [15:0] xbus_rd_in,
	input wire logic [15:0] ybus_rd_in,
	input wire logic [15:0] wdata_in,
	input wire logic div_start_in,
	input wire dmd_pkg::dmd_div_t div_kind_in,
	output logic [15:0] xaddr_out,
	output logic [15:0] yaddr_out,
	output logic y_space_out,
	output logic [15:0] wr_data_out,
	output logic wr_en_out,
	output logic [39:0] acca_out,
	output logic [39:0] accb_out,
	output logic acc_ovf_out,
	output logic [15:0] result_out,
	output logic [15:0] stack_ptr_out,
	output logic multi_cycle_out,
	output logic div_busy_out
);
	logic [15:0] wreg_r [NUM_REGS];
	logic [39:0] acc_r [2];
	logic [39:0] acc_nxt;
	logic [15:0] xaddr_r, yaddr_r, wr_data_r, result_r, result_nxt;
	logic ysp_r, wr_en_r, ovf_r, mcyc_r;
	logic [15:0] opa, opb;
	logic [16:0] mul_a, mul_b;
	logic signed [33:0] prod;
	logic [39:0] prod_ext, acc_sel, alu_sum, alu_out;
	logic [40:0] sum_wide;
	logic alu_ovf;
	logic [39:0] sh_src, sh_res;
	logic [4:0] sh_mag;
	logic sh_right;
	logic [15:0] rnd_word;
	logic rnd_ovf, acc_hi_ovf;
	logic [15:0] sat_word;
	logic [15:0] div_q, div_rem;
	logic div_done;
	logic reg_we;

	// Saturating 40-bit add: clamp on signed overflow when asked [RL4]
	function automatic logic [39:0] sat40(input logic [40:0] s,
		input logic en);
		logic ov;
		ov = s[40] != s[39];
		if (en && ov) begin
			sat40 = s[40] ? dmd_pkg::ACC_MIN : dmd_pkg::ACC_MAX;
		end else begin
			sat40 = s[39:0];
		end
	endfunction

	// One read port per register source; address flops and divider read wreg_r directly
	assign opa = wreg_r[src_a_in]; // [RL19]
	assign opb = wreg_r[src_b_in];
	assign acc_sel = acc_r[acc_sel_in];

	// 17-bit extension chooses sign mode; -1 x -1 cannot wrap [RL2] [RL3]
	assign mul_a = {(mul_mode_in != dmd_pkg::DMD_MUL_UU) & opa[15], opa};
	assign mul_b = {(mul_mode_in == dmd_pkg::DMD_MUL_SS) & opb[15], opb};
	assign prod = $signed(mul_a) * $signed(mul_b); // [RL1]
	// Fractional mode shifts left once; 34 bits keep +1.0 representable
	assign prod_ext = frac_mode_in ? {{5{prod[33]}}, prod, 1'b0} :
		{{6{prod[33]}}, prod};

	// ALU adds the product, or adds or subtracts a bus word, into the chosen accumulator
	assign alu_sum = (op_in == dmd_pkg::DMD_OP_ADD ||
		op_in == dmd_pkg::DMD_OP_SUB) ?
		{{8{xbus_rd_in[15]}}, xbus_rd_in, 16'h0000} : prod_ext;
	assign sum_wide = (op_in == dmd_pkg::DMD_OP_SUB) ?
		{acc_sel[39], acc_sel} - {alu_sum[39], alu_sum} :
		{acc_sel[39], acc_sel} + {alu_sum[39], alu_sum}; // [RL7]
	assign alu_ovf = sum_wide[40] != sum_wide[39];
	assign alu_out = sat40(sum_wide, acc_sat_en_in); // [RL4]

	// Shifter source: accumulator, or register word opa placed per direction
	assign sh_right = !shift_amt_in[5]; // [RL21]
	assign sh_mag = sh_right ? shift_amt_in[4:0] : 5'(-shift_amt_in);
	assign sh_src = (op_in == dmd_pkg::DMD_OP_SHIFT_ACC) ? acc_sel :
		sh_right ? {{8{arith_shift_in & opa[15]}}, opa, 16'h0000} :
		{24'h000000, opa}; // [RL22] [RL6]
	assign sh_res = sh_right ?
		(arith_shift_in ? 40'($signed(sh_src) >>> sh_mag) :
		sh_src >> sh_mag) : sh_src << sh_mag; // [RL5]

	// Round stage: bits 31:16 with optional round-half-up from bit 15
	assign {rnd_ovf, rnd_word} = {1'b0, acc_sel[31:16]} +
		{16'h0000, round_en_in & acc_sel[15]};
	assign acc_hi_ovf = |(acc_sel[39:31] ^ {9{acc_sel[39]}});

	// Store saturation: accumulator is only read here, never written
	assign sat_word = !data_write_saturate_enable_in ? rnd_word : // [RL17]
		(!acc_sel[dmd_pkg::ACC_SIGN_BIT] && (acc_hi_ovf ||
		(rnd_ovf | (rnd_word[15] & ~acc_sel[31])))) ?
		dmd_pkg::SAT_POS : // [RL14] [RL16] [RL13]
		(acc_sel[dmd_pkg::ACC_SIGN_BIT] && acc_hi_ovf) ?
		dmd_pkg::SAT_NEG : rnd_word; // [RL15] [RL12]

	// Register writes: MCU results, MCU shifts, divide, or host load
	assign reg_we = op_in == dmd_pkg::DMD_OP_MUL ||
		op_in == dmd_pkg::DMD_OP_SHIFT_REG ||
		op_in == dmd_pkg::DMD_OP_WRITE_REG || div_done;
	always_comb begin
		result_nxt = result_r;
		unique case (op_in)
			dmd_pkg::DMD_OP_MUL: result_nxt = prod_ext[15:0];
			dmd_pkg::DMD_OP_SHIFT_REG: result_nxt = sh_right ?
				sh_res[31:16] : sh_res[15:0]; // [RL22]
			dmd_pkg::DMD_OP_WRITE_REG: result_nxt = wdata_in;
			dmd_pkg::DMD_OP_STORE_ACC: result_nxt = sat_word;
			default: result_nxt = result_r;
		endcase
		if (div_done) begin
			result_nxt = div_q;
		end
	end

	// Accumulator update selection
	always_comb begin
		acc_nxt = acc_sel;
		if (op_in == dmd_pkg::DMD_OP_MAC || op_in == dmd_pkg::DMD_OP_ADD ||
			op_in == dmd_pkg::DMD_OP_SUB) begin
			acc_nxt = alu_out;
		end else if (op_in == dmd_pkg::DMD_OP_SHIFT_ACC) begin
			acc_nxt = sh_res;
		end
	end

	dmd_div_unit u_div (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.start_in(div_start_in),
		.step_in(op_in == dmd_pkg::DMD_OP_DIV), // [RL10] [RL9]
		.kind_in(div_kind_in),
		.dividend_in({wreg_r[src_b_in], opa}),
		.divisor_in(wreg_r[dst_in]),
		.busy_out(div_busy_out),
		.done_out(div_done),
		.quot_out(div_q),
		.rem_out(div_rem)
	);

	// Working register file; highest index doubles as stack pointer
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				wreg_r[i] <= dmd_pkg::REG_RESET;
			end
		end else if (div_done) begin
			wreg_r[0] <= div_q;
			wreg_r[1] <= div_rem;
		end else if (reg_we) begin
			wreg_r[dst_in] <= result_nxt; // [RL18]
		end
	end

	// Two accumulators, only the selected one changes [RL4]
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			acc_r[0] <= 40'h0000000000;
			acc_r[1] <= 40'h0000000000;
		end else begin
			acc_r[acc_sel_in] <= acc_nxt;
		end
	end

	// Output flops: dual fetch addresses, store path, status
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			xaddr_r <= 16'h0000;
			yaddr_r <= 16'h0000;
			ysp_r <= 1'b0;
			wr_data_r <= 16'h0000;
			wr_en_r <= 1'b0;
			ovf_r <= 1'b0;
			result_r <= 16'h0000;
			mcyc_r <= 1'b0;
		end else begin
			xaddr_r <= wreg_r[xaddr_reg_in];
			yaddr_r <= wreg_r[yaddr_reg_in]; // [RL8]
			ysp_r <= op_in == dmd_pkg::DMD_OP_MAC; // [RL7] [RL8]
			wr_data_r <= sat_word; // [RL19]
			wr_en_r <= op_in == dmd_pkg::DMD_OP_STORE_ACC;
			ovf_r <= alu_ovf;
			result_r <= result_nxt;
			mcyc_r <= op_in == dmd_pkg::DMD_OP_DWMOVE; // [RL20]
		end
	end

	assign xaddr_out = xaddr_r;
	assign yaddr_out = yaddr_r;
	assign y_space_out = ysp_r;
	assign wr_data_out = wr_data_r;
	assign wr_en_out = wr_en_r;
	assign acca_out = acc_r[0];
	assign accb_out = acc_r[1];
	assign acc_ovf_out = ovf_r;
	assign result_out = result_r;
	assign stack_ptr_out = wreg_r[dmd_pkg::SP_IDX]; // [RL18]
	assign multi_cycle_out = mcyc_r;

	a_store_sat_pos: assert property (@(posedge clk_sys_in) // [RL14]
		disable iff (!resetn_in) op_in == dmd_pkg::DMD_OP_STORE_ACC &&
		data_write_saturate_enable_in && !acc_sel[39] && acc_hi_ovf
		|=> wr_data_out == 16'h7fff)
		else $error("positive store saturation missed");
	a_store_sat_neg: assert property (@(posedge clk_sys_in) // [RL15]
		disable iff (!resetn_in) op_in == dmd_pkg::DMD_OP_STORE_ACC &&
		data_write_saturate_enable_in && acc_sel[39] && acc_hi_ovf
		|=> wr_data_out == 16'h8000)
		else $error("negative store saturation missed");
	a_store_pass: assert property (@(posedge clk_sys_in) // [RL17]
		disable iff (!resetn_in) !data_write_saturate_enable_in
		|=> wr_data_out == $past(rnd_word))
		else $error("store word altered with saturation off");
	a_store_keeps_acc: assert property (@(posedge clk_sys_in) // [RL12]
		disable iff (!resetn_in) op_in == dmd_pkg::DMD_OP_STORE_ACC
		|=> acca_out == $past(acca_out) && accb_out == $past(accb_out))
		else $error("store changed accumulator");
	a_mul_minus_one: assert property (@(posedge clk_sys_in) // [RL3]
		disable iff (!resetn_in) op_in == dmd_pkg::DMD_OP_MAC &&
		frac_mode_in && mul_mode_in == dmd_pkg::DMD_MUL_SS &&
		opa == 16'h8000 && opb == 16'h8000 && acc_sel == 40'h0 &&
		!acc_sel_in |=> acca_out == 40'h0080000000)
		else $error("minus one squared wrapped");
	a_shift_zero: assert property (@(posedge clk_sys_in) // [RL21]
		disable iff (!resetn_in) op_in == dmd_pkg::DMD_OP_SHIFT_ACC &&
		shift_amt_in == 6'sd0 && !acc_sel_in
		|=> acca_out == $past(acca_out))
		else $error("zero shift changed operand");
	a_div_length: assert property (@(posedge clk_sys_in) // [RL10]
		disable iff (!resetn_in) div_start_in ##1
		(op_in == dmd_pkg::DMD_OP_DIV) [*8] |-> div_busy_out)
		else $error("divide ended early");
	a_mac_ysp: assert property (@(posedge clk_sys_in) // [RL8]
		disable iff (!resetn_in) op_in == dmd_pkg::DMD_OP_MAC
		|=> y_space_out)
		else $error("dual fetch space not split");
	c_mac: cover property (@(posedge clk_sys_in)
		op_in == dmd_pkg::DMD_OP_MAC && alu_ovf);
	c_store_sat: cover property (@(posedge clk_sys_in)
		wr_en_out && wr_data_out == 16'h7fff);
	c_div_done: cover property (@(posedge clk_sys_in) div_done);
endmodule

// >>> bench/dmd_dmem_model.sv
// Data memory model facing the datapath address and write ports
`timescale 1ns/10ps
module dmd_dmem_model (
	input wire logic clk_sys_in,
	input wire logic [15:0] xaddr_in,
	input wire logic [15:0] yaddr_in,
	input wire logic [15:0] wr_data_in,
	input wire logic wr_en_in,
	output logic [15:0] xrd_out,
	output logic [15:0] yrd_out
);
	logic [15:0] mem [16];
	// One read per space and one write per cycle
	assign xrd_out = mem[xaddr_in[3:0]];
	assign yrd_out = mem[yaddr_in[3:0]];
	// Store lands at the X address of the write cycle
	always @(posedge clk_sys_in) begin
		if (wr_en_in === 1'b1) begin
			mem[xaddr_in[3:0]] <= wr_data_in;
		end
	end
endmodule

// >>> bench/dsp_math_datapath_test.sv
// Self-checking bench for the arithmetic datapath
`timescale 1ns/10ps
module dsp_math_datapath_test;
	logic clk_sys_in = 0, resetn_in = 0, frac_mode_in = 0, acc_sel_in = 0;
	logic acc_sat_en_in = 0, data_write_saturate_enable_in = 0;
	logic round_en_in = 0, arith_shift_in = 1, div_start_in = 0;
	logic signed [5:0] shift_amt_in = 0;
	logic [3:0] src_a_in = 0, src_b_in = 0, dst_in = 0;
	logic [3:0] xaddr_reg_in = 0, yaddr_reg_in = 0;
	logic [15:0] xbus_rd_in, ybus_rd_in, wdata_in = 0;
	dmd_pkg::dmd_op_t op_in = dmd_pkg::DMD_OP_NOP;
	dmd_pkg::dmd_mul_mode_t mul_mode_in = dmd_pkg::DMD_MUL_SS;
	dmd_pkg::dmd_div_t div_kind_in = dmd_pkg::DMD_DIV_16_INT;
	logic [15:0] xaddr_out, yaddr_out, wr_data_out, result_out, stack_ptr_out;
	logic [39:0] acca_out, accb_out;
	logic y_space_out, wr_en_out, acc_ovf_out, multi_cycle_out, div_busy_out;
	int n_mismatch = 0;
	int checked = 0;

	dmd_math_datapath dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.op_in(op_in), .mul_mode_in(mul_mode_in), .frac_mode_in(frac_mode_in),
		.acc_sel_in(acc_sel_in), .acc_sat_en_in(acc_sat_en_in),
		.data_write_saturate_enable_in(data_write_saturate_enable_in),
		.round_en_in(round_en_in), .arith_shift_in(arith_shift_in),
		.shift_amt_in(shift_amt_in), .src_a_in(src_a_in), .src_b_in(src_b_in),
		.dst_in(dst_in), .xaddr_reg_in(xaddr_reg_in),
		.yaddr_reg_in(yaddr_reg_in), .xbus_rd_in(xbus_rd_in),
		.ybus_rd_in(ybus_rd_in), .wdata_in(wdata_in),
		.div_start_in(div_start_in), .div_kind_in(div_kind_in),
		.xaddr_out(xaddr_out), .yaddr_out(yaddr_out), .y_space_out(y_space_out),
		.wr_data_out(wr_data_out), .wr_en_out(wr_en_out), .acca_out(acca_out),
		.accb_out(accb_out), .acc_ovf_out(acc_ovf_out), .result_out(result_out),
		.stack_ptr_out(stack_ptr_out), .multi_cycle_out(multi_cycle_out),
		.div_busy_out(div_busy_out));
	dmd_dmem_model mem (.clk_sys_in(clk_sys_in), .xaddr_in(xaddr_out),
		.yaddr_in(yaddr_out), .wr_data_in(wr_data_out), .wr_en_in(wr_en_out),
		.xrd_out(xbus_rd_in), .yrd_out(ybus_rd_in));

	// 40 MHz clock
	initial begin
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	task automatic chk(input string nm, input logic [39:0] e,
			input logic [39:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One op for one cycle; returns where the registered answer is settled
	task automatic issue(input dmd_pkg::dmd_op_t o);
		@(negedge clk_sys_in);
		op_in = o;
		@(negedge clk_sys_in);
		op_in = dmd_pkg::DMD_OP_NOP;
	endtask

	task automatic wreg(input logic [3:0] idx, input logic [15:0] v);
		dst_in = idx;
		wdata_in = v;
		issue(dmd_pkg::DMD_OP_WRITE_REG);
	endtask

	task automatic t_regs();
		wreg(4'hf, 16'h0ffe);
		wreg(4'h7, 16'h0003);
		xaddr_reg_in = 4'h7;
		repeat (2) @(negedge clk_sys_in);
		chk("stack_ptr", 40'h0ffe, stack_ptr_out);
		chk("xaddr", 40'h0003, xaddr_out);
	endtask

	// Sign modes accumulate into B; fractional -1 x -1 into A
	task automatic t_mac();
		wreg(4'h2, 16'hffff);
		wreg(4'h3, 16'h0002);
		acc_sel_in = 1;
		src_a_in = 4'h2;
		src_b_in = 4'h3;
		mul_mode_in = dmd_pkg::DMD_MUL_UU;
		issue(dmd_pkg::DMD_OP_MAC);
		chk("mac_uu", 40'h000001fffe, accb_out);
		chk("y_space", 40'h1, y_space_out);
		mul_mode_in = dmd_pkg::DMD_MUL_SS;
		issue(dmd_pkg::DMD_OP_MAC);
		chk("mac_ss", 40'h000001fffc, accb_out);
		chk("y_space_ss", 40'h1, y_space_out);
		src_a_in = 4'h3;
		src_b_in = 4'h2;
		mul_mode_in = dmd_pkg::DMD_MUL_SU;
		issue(dmd_pkg::DMD_OP_MAC);
		chk("mac_su", 40'h000003fffa, accb_out);
		wreg(4'h2, 16'h8000);
		chk("y_space_off", 40'h0, y_space_out);
		wreg(4'h3, 16'h8000);
		acc_sel_in = 0;
		src_a_in = 4'h2;
		mul_mode_in = dmd_pkg::DMD_MUL_SS;
		frac_mode_in = 1;
		issue(dmd_pkg::DMD_OP_MAC);
		chk("mac_frac", 40'h0080000000, acca_out);
		chk("acc_b_kept", 40'h000003fffa, accb_out);
		frac_mode_in = 0;
	endtask

	// Negative store from B, then positive from A, with and without clamp
	task automatic t_store();
		acc_sel_in = 1;
		repeat (3) issue(dmd_pkg::DMD_OP_SUB);
		chk("acc_b_sub", 40'hff4003fffa, accb_out);
		data_write_saturate_enable_in = 1;
		issue(dmd_pkg::DMD_OP_STORE_ACC);
		chk("wr_en", 40'h1, wr_en_out);
		chk("store_neg", 40'h8000, wr_data_out);
		data_write_saturate_enable_in = 0;
		issue(dmd_pkg::DMD_OP_STORE_ACC);
		chk("store_raw_neg", 40'h4003, wr_data_out);
		acc_sel_in = 0;
		data_write_saturate_enable_in = 1;
		issue(dmd_pkg::DMD_OP_STORE_ACC);
		chk("store_pos", 40'h7fff, wr_data_out);
		chk("acc_kept", 40'h0080000000, acca_out);
		data_write_saturate_enable_in = 0;
		issue(dmd_pkg::DMD_OP_STORE_ACC);
		chk("store_raw_pos", 40'h8000, wr_data_out);
		@(negedge clk_sys_in);
		chk("mem_word", 40'h8000, mem.mem[3]);
	endtask

	// Both directions, zero and the 16-position limit
	task automatic t_shift();
		shift_amt_in = 6'sd4;
		issue(dmd_pkg::DMD_OP_SHIFT_ACC);
		chk("shr4", 40'h0008000000, acca_out);
		shift_amt_in = -6'sd4;
		issue(dmd_pkg::DMD_OP_SHIFT_ACC);
		chk("shl4", 40'h0080000000, acca_out);
		shift_amt_in = 6'sd0;
		issue(dmd_pkg::DMD_OP_SHIFT_ACC);
		chk("sh0", 40'h0080000000, acca_out);
		shift_amt_in = 6'sd16;
		issue(dmd_pkg::DMD_OP_SHIFT_ACC);
		chk("shr16", 40'h0000008000, acca_out);
		shift_amt_in = 6'sd4;
		issue(dmd_pkg::DMD_OP_SHIFT_REG);
		chk("mcu_shr4", 40'hf800, result_out);
		arith_shift_in = 0;
		issue(dmd_pkg::DMD_OP_SHIFT_REG);
		chk("mcu_lsr4", 40'h0800, result_out);
	endtask

	// Left shifts build the most negative value, then an ADD overflows it
	task automatic t_sat();
		shift_amt_in = -6'sd16;
		issue(dmd_pkg::DMD_OP_SHIFT_ACC);
		chk("shl16", 40'h0080000000, acca_out);
		shift_amt_in = -6'sd8;
		issue(dmd_pkg::DMD_OP_SHIFT_ACC);
		chk("shl8_top", 40'h8000000000, acca_out);
		acc_sat_en_in = 1;
		issue(dmd_pkg::DMD_OP_ADD);
		chk("add_sat", 40'h8000000000, acca_out);
		chk("acc_ovf", 40'h1, acc_ovf_out);
		acc_sat_en_in = 0;
		issue(dmd_pkg::DMD_OP_ADD);
		chk("add_wrap", 40'h7f80000000, acca_out);
	endtask

	// Divide with an interruption of NOPs between steps
	task automatic t_div(input dmd_pkg::dmd_div_t k, input logic [15:0] hi,
			input logic [15:0] q, input logic [15:0] r);
		wreg(4'h4, 16'h0064);
		wreg(4'h5, hi);
		wreg(4'h6, 16'h0007);
		src_a_in = 4'h4;
		src_b_in = 4'h5;
		div_kind_in = k;
		@(negedge clk_sys_in);
		div_start_in = 1;
		@(negedge clk_sys_in);
		div_start_in = 0;
		op_in = dmd_pkg::DMD_OP_DIV;
		repeat (8) @(negedge clk_sys_in);
		op_in = dmd_pkg::DMD_OP_NOP;
		repeat (3) @(negedge clk_sys_in);
		chk("div_busy", 40'h1, div_busy_out);
		op_in = dmd_pkg::DMD_OP_DIV;
		repeat (9) @(negedge clk_sys_in);
		op_in = dmd_pkg::DMD_OP_NOP;
		xaddr_reg_in = 4'h0;
		yaddr_reg_in = 4'h1;
		repeat (3) @(negedge clk_sys_in);
		chk("quot", {24'h0, q}, xaddr_out);
		chk("rem", {24'h0, r}, yaddr_out);
		chk("div_idle", 40'h0, div_busy_out);
	endtask

	task automatic final_report();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Whole run is about 130 cycles; allow ample margin
	initial begin
		#(25 * 5000);
		n_mismatch++;
		final_report();
	end

	initial begin
		mem.mem[3] = 16'h4000;
		repeat (6) @(negedge clk_sys_in);
		chk("rst_acc", 40'h0, acca_out);
		chk("rst_wr_en", 40'h0, wr_en_out);
		resetn_in = 1;
		t_regs();
		t_mac();
		t_store();
		t_shift();
		t_sat();
		t_div(dmd_pkg::DMD_DIV_16_INT, 16'h0000, 16'd14, 16'd2);
		t_div(dmd_pkg::DMD_DIV_32_INT, 16'h0001, 16'd9376, 16'd4);
		issue(dmd_pkg::DMD_OP_DWMOVE);
		chk("dwmove_multi", 40'h1, multi_cycle_out);
		issue(dmd_pkg::DMD_OP_ADD);
		chk("add_single", 40'h0, multi_cycle_out);
		final_report();
	end
endmodule
